// >>> rtl/bes_params.svh
// Function
// - Input and output streams use ready latency zero; transfer when ready seen high.
// - Every register of the encoder runs on the single clock mclk.
// - While sink_valid is low the block stalls until it is raised again.
// - A block carrying any non-zero input error value is discarded, not encoded.
// - The input error value is copied to source_error a few cycles later.
// - source_error: 00 none, 01 no start, 10 no end, 11 unexpected end or other.
// - sink_ready is high only in cycles where an input word can be taken.
// - source_valid is high exactly while an encoded word is on the output.
// - First encoded word carries source_sop, last encoded word carries source_eop.
// - Block length comes in on the input size field and goes out likewise.
// - Encoding a K-bit block takes K+14 cycles after a K-cycle load.
// - Input word: block size in bits 13:1, data bit in bit 0.
// - Output word: block size in bits 15:3, three encoded bits in 2:0.
`ifndef BES_PARAMS_SVH
`define BES_PARAMS_SVH

`define BES_KMAX 6144
`define BES_SIZE_W 13
`define BES_CNT_W 14
`define BES_FIFO_DEPTH 4
`define BES_ENC_LAT 14'h000A
`define BES_TAIL_WORDS 14'h0004
`define BES_ERR_NONE 2'h0
`define BES_ERR_NO_SOP 2'h1
`define BES_ERR_NO_EOP 2'h2
`define BES_ERR_BAD_EOP 2'h3

`endif

// >>> rtl/bes_pkg.sv
package bes_pkg;

    // Input beat: size in 13:1, data bit in 0
    typedef struct packed {
        logic [12:0] size;
        logic data;
    } bes_in_t;

    // Output beat: size in 15:3, encoded triplet in 2:0
    typedef struct packed {
        logic [12:0] size;
        logic [2:0] data;
    } bes_out_t;

    typedef struct packed {
        logic sop;
        logic eop;
        bes_out_t word;
    } bes_beat_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_LOAD = 3'b010,
        ST_ENC = 3'b100
    } bes_state_t;

endpackage

// >>> rtl/bes_fifo.sv
`timescale 1ns/100ps
module bes_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 4
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [AW:0] cnt_r, cnt_nxt;
    logic push, pop;

    ////////////////////////////////////////////////////////////////////////////
    assign in_ready = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign out_data = mem[rp_r];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        wp_nxt = wp_r;
        rp_nxt = rp_r;
        cnt_nxt = cnt_r;
        if (push) begin
            wp_nxt = (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
        end
        if (pop) begin
            rp_nxt = (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
        end
        if (push && !pop) begin
            cnt_nxt = cnt_r + 1'b1;
        end else if (pop && !push) begin
            cnt_nxt = cnt_r - 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // Storage needs no reset; a slot is only read after it was written
    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wp_r] <= in_data;
        end
    end
endmodule

// >>> rtl/bes_encoder.sv
`timescale 1ns/100ps
`include "bes_params.svh"
module bes_encoder (
    input wire logic mclk,
    input wire logic reset_n,
    input wire bes_pkg::bes_in_t sink_word,
    input wire logic sink_valid,
    input wire logic sink_sop,
    input wire logic sink_eop,
    input wire logic [1:0] sink_error,
    output logic sink_ready,
    input wire logic [12:0] ilv_f1,
    input wire logic [12:0] ilv_f2,
    output bes_pkg::bes_out_t source_word,
    output logic source_valid,
    output logic source_sop,
    output logic source_eop,
    output logic [1:0] source_error,
    input wire logic source_ready
);
    import bes_pkg::*;

    // Constituent code: feedback 1+D2+D3, parity 1+D+D3; returns {z, next state}
    function automatic logic [3:0] rsc_step(input logic [2:0] s, input logic x);
        logic fb;
        fb = x ^ s[1] ^ s[2];
        return {fb ^ s[0] ^ s[2], s[1], s[0], fb};
    endfunction

    // Three termination steps; returns {z2, x2, z1, x1, z0, x0}
    function automatic logic [5:0] tail_bits(input logic [2:0] s0);
        logic [2:0] s;
        logic [5:0] t;
        s = s0;
        t = '0;
        for (int i = 0; i < 3; i++) begin
            t[2*i] = s[1] ^ s[2];
            t[2*i+1] = s[0] ^ s[2];
            s = {s[1], s[0], 1'b0};
        end
        return t;
    endfunction

    function automatic logic [12:0] mod_add(input logic [12:0] a, input logic [12:0] b,
                                            input logic [12:0] k);
        logic [13:0] sum;
        sum = {1'b0, a} + {1'b0, b};
        if (sum >= {1'b0, k}) begin
            sum = sum - {1'b0, k};
        end
        return sum[12:0];
    endfunction

    logic blk_mem [0:`BES_KMAX-1];

    bes_state_t state_r, state_nxt;
    logic [12:0] k_r, k_nxt, pi_r, pi_nxt, g_r, g_nxt, f2_r, f2_nxt;
    logic [13:0] cnt_r, cnt_nxt;
    logic [2:0] s1_r, s1_nxt, s2_r, s2_nxt;
    logic bad_r, bad_nxt;
    logic [1:0] code_r, code_nxt;
    logic [1:0] pend_r, pend_nxt, err_out_r, err_out_nxt;
    logic have_r, have_nxt;

    logic beat, start, last, mem_we;
    logic [13:0] pos, idx;
    logic [12:0] kk;
    logic ev_valid;
    logic [1:0] ev_code;
    logic emit, fifo_ready;
    logic [3:0] st1, st2;
    logic [5:0] t1, t2;
    bes_beat_t push_beat, pop_beat;
    logic out_hold;

    ////////////////////////////////////////////////////////////////////////////
    // Input side
    assign sink_ready = (state_r == ST_IDLE) || (state_r == ST_LOAD);
    assign beat = sink_valid && sink_ready;
    assign start = (state_r == ST_IDLE) || sink_sop;
    assign pos = start ? '0 : cnt_r;
    assign kk = start ? sink_word.size : k_r;
    assign last = (pos == ({1'b0, kk} - 14'h0001));
    assign mem_we = beat && !((state_r == ST_IDLE) && !sink_sop);

    // Encoder datapath
    assign idx = cnt_r - `BES_ENC_LAT;
    assign emit = (state_r == ST_ENC) && (cnt_r >= `BES_ENC_LAT);
    assign st1 = rsc_step(s1_r, blk_mem[idx[12:0]]);
    assign st2 = rsc_step(s2_r, blk_mem[pi_r]);
    assign t1 = tail_bits(s1_r);
    assign t2 = tail_bits(s2_r);

    always_comb begin
        push_beat.word.size = k_r;
        push_beat.sop = (idx == '0);
        push_beat.eop = (idx == {1'b0, k_r} + `BES_TAIL_WORDS - 14'h0001);
        if (idx < {1'b0, k_r}) begin
            push_beat.word.data = {st2[3], st1[3], blk_mem[idx[12:0]]};
        end else if (idx == {1'b0, k_r}) begin
            push_beat.word.data = {t1[2], t1[1], t1[0]};
        end else if (idx == {1'b0, k_r} + 14'h0001) begin
            push_beat.word.data = {t1[5], t1[4], t1[3]};
        end else if (idx == {1'b0, k_r} + 14'h0002) begin
            push_beat.word.data = {t2[2], t2[1], t2[0]};
        end else begin
            push_beat.word.data = {t2[5], t2[4], t2[3]};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control
    always_comb begin
        state_nxt = state_r;
        k_nxt = k_r;
        cnt_nxt = cnt_r;
        pi_nxt = pi_r;
        g_nxt = g_r;
        f2_nxt = f2_r;
        s1_nxt = s1_r;
        s2_nxt = s2_r;
        bad_nxt = bad_r;
        code_nxt = code_r;
        ev_valid = 1'b0;
        ev_code = `BES_ERR_NONE;
        case (state_r)
            ST_IDLE, ST_LOAD: begin
                if (beat && (state_r == ST_IDLE) && !sink_sop) begin
                    ev_valid = 1'b1;
                    ev_code = (sink_error != `BES_ERR_NONE) ? sink_error : `BES_ERR_NO_SOP;
                end else if (beat) begin
                    if ((state_r == ST_LOAD) && sink_sop) begin
                        ev_valid = 1'b1;
                        ev_code = bad_r ? code_r : `BES_ERR_NO_EOP;
                    end
                    k_nxt = kk;
                    bad_nxt = (start ? 1'b0 : bad_r) || (sink_error != `BES_ERR_NONE);
                    code_nxt = (sink_error != `BES_ERR_NONE) ? sink_error : (start ? `BES_ERR_NONE : code_r);
                    cnt_nxt = pos + 14'h0001;
                    state_nxt = ST_LOAD;
                    if (sink_eop && !last) begin
                        ev_valid = 1'b1;
                        ev_code = bad_nxt ? code_nxt : `BES_ERR_BAD_EOP;
                        state_nxt = ST_IDLE;
                    end else if (last && !sink_eop) begin
                        ev_valid = 1'b1;
                        ev_code = bad_nxt ? code_nxt : `BES_ERR_NO_EOP;
                        state_nxt = ST_IDLE;
                    end else if (last) begin
                        ev_valid = 1'b1;
                        ev_code = code_nxt;
                        if (bad_nxt) begin
                            state_nxt = ST_IDLE;
                        end else begin
                            state_nxt = ST_ENC;
                            cnt_nxt = '0;
                            pi_nxt = '0;
                            g_nxt = mod_add(ilv_f1, ilv_f2, kk);
                            f2_nxt = mod_add(ilv_f2, ilv_f2, kk);
                            s1_nxt = '0;
                            s2_nxt = '0;
                        end
                    end
                    // An errored beat is reported at once, not only when the block ends
                    if (sink_error != `BES_ERR_NONE) begin
                        ev_valid = 1'b1;
                        ev_code = sink_error;
                    end
                end
            end
            ST_ENC: begin
                // Stall only where a word must enter a full buffer
                if (!emit || fifo_ready) begin
                    cnt_nxt = cnt_r + 14'h0001;
                    if (emit && (idx < {1'b0, k_r})) begin
                        s1_nxt = st1[2:0];
                        s2_nxt = st2[2:0];
                        pi_nxt = mod_add(pi_r, g_r, k_r);
                        g_nxt = mod_add(g_r, f2_r, k_r);
                    end
                    if (cnt_r == {1'b0, k_r} + `BES_ENC_LAT + `BES_TAIL_WORDS - 14'h0001) begin
                        state_nxt = ST_IDLE;
                    end
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Error forwarding; a fresh event is queued behind the hand-off to the output
    assign out_hold = source_valid && !source_ready;

    always_comb begin
        pend_nxt = pend_r;
        have_nxt = have_r;
        err_out_nxt = err_out_r;
        if (have_r && !out_hold) begin
            err_out_nxt = pend_r;
            have_nxt = 1'b0;
        end
        if (ev_valid) begin
            pend_nxt = ev_code;
            have_nxt = 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= ST_IDLE;
            k_r <= '0;
            cnt_r <= '0;
            pi_r <= '0;
            g_r <= '0;
            f2_r <= '0;
            s1_r <= '0;
            s2_r <= '0;
            bad_r <= 1'b0;
            code_r <= `BES_ERR_NONE;
            pend_r <= `BES_ERR_NONE;
            have_r <= 1'b0;
            err_out_r <= `BES_ERR_NONE;
        end else begin
            state_r <= state_nxt;
            k_r <= k_nxt;
            cnt_r <= cnt_nxt;
            pi_r <= pi_nxt;
            g_r <= g_nxt;
            f2_r <= f2_nxt;
            s1_r <= s1_nxt;
            s2_r <= s2_nxt;
            bad_r <= bad_nxt;
            code_r <= code_nxt;
            pend_r <= pend_nxt;
            have_r <= have_nxt;
            err_out_r <= err_out_nxt;
        end
    end

    // Block buffer; contents are meaningless until a full block is loaded
    always_ff @(posedge mclk) begin
        if (mem_we) begin
            blk_mem[pos[12:0]] <= sink_word.data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output buffer decouples encoder from downstream stalls
    bes_fifo #(
        .WIDTH($bits(bes_beat_t)),
        .DEPTH(`BES_FIFO_DEPTH)
    ) u_fifo (
        .mclk(mclk),
        .reset_n(reset_n),
        .in_valid(emit),
        .in_ready(fifo_ready),
        .in_data(push_beat),
        .out_valid(source_valid),
        .out_ready(source_ready),
        .out_data(pop_beat)
    );

    assign source_word = pop_beat.word;
    assign source_sop = pop_beat.sop;
    assign source_eop = pop_beat.eop;
    assign source_error = err_out_r;
endmodule

// >>> test/bes_encoder_props.sv
`timescale 1ns/100ps
module bes_encoder_props
    import bes_pkg::*;
(
    input wire logic mclk,
    input wire logic reset_n,
    input wire bes_in_t sink_word,
    input wire logic sink_valid,
    input wire logic sink_sop,
    input wire logic sink_eop,
    input wire logic [1:0] sink_error,
    input wire logic sink_ready,
    input wire bes_out_t source_word,
    input wire logic source_valid,
    input wire logic source_sop,
    input wire logic source_eop,
    input wire logic [1:0] source_error,
    input wire logic source_ready
);
    logic acc;
    logic last_ok;
    logic inb_r, inb_nxt, eb_r, eb_nxt;
    logic [12:0] bc_r, bc_nxt, kin_r, kin_nxt, kout_r, kout_nxt;
    logic [13:0] oc_r, oc_nxt;
    logic [1:0] ein_r, ein_nxt;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    assign acc = sink_valid && sink_ready;
    assign last_ok = acc && sink_eop && sink_error == 2'h0
        && (sink_sop ? sink_word.size == 13'h0001 : inb_r && !eb_r && bc_r + 13'h0001 == kin_r);
    always_comb begin
        {inb_nxt, bc_nxt, kin_nxt, kout_nxt, oc_nxt, ein_nxt} = {inb_r, bc_r, kin_r, kout_r, oc_r, ein_r};
        eb_nxt = eb_r;
        if (acc) begin
            inb_nxt = (inb_r || sink_sop) && !sink_eop;
            eb_nxt = (eb_r && !sink_sop) || (sink_error != 2'h0);
            bc_nxt = sink_sop ? 13'h0001 : bc_r + 13'h0001;
            if (sink_sop) kin_nxt = sink_word.size;
            if (sink_error != 2'h0) ein_nxt = sink_error;
        end
        if (last_ok) kout_nxt = sink_sop ? sink_word.size : kin_r;
        if (source_valid && source_ready) oc_nxt = source_eop ? 14'h0000 : oc_r + 14'h0001;
    end
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) {eb_r, inb_r, bc_r, kin_r, kout_r, oc_r, ein_r} <= '0;
        else {eb_r, inb_r, bc_r, kin_r, kout_r, oc_r, ein_r} <= {eb_nxt, inb_nxt, bc_nxt, kin_nxt, kout_nxt, oc_nxt, ein_nxt};
    end
    ////////////////////////////////////////////////////////////////////////
    a_out_hold: assert property (source_valid && !source_ready |=> source_valid
        && $stable(source_word) && $stable(source_sop) && $stable(source_eop)) else $error("output moved while held");
    a_err_hold: assert property (source_valid && !source_ready |=> $stable(source_error))
        else $error("error moved while held");
    a_sop_first: assert property (source_valid && source_sop |-> oc_r == 14'h0000) else $error("sop not first");
    a_eop_last: assert property (source_valid && source_eop |-> oc_r == {1'b0, kout_r} + 14'h0003)
        else $error("eop not on word K+3");
    a_size_out: assert property (source_valid |-> source_word.size == kout_r) else $error("size wrong");
    a_busy_load: assert property (last_ok |=> !sink_ready [*8]) else $error("ready during encode");
    a_first_out: assert property (last_ok |-> ##[11:13] (source_valid && source_sop))
        else $error("first word late");
    a_err_good: assert property (last_ok |-> ##[1:4] source_error == 2'h0) else $error("good block flagged");
    a_err_copy: assert property (acc && sink_error != 2'h0 |-> ##[1:4] source_error == ein_r)
        else $error("error not copied");
endmodule
bind bes_encoder bes_encoder_props i_bes_encoder_props (.mclk(mclk), .reset_n(reset_n), .sink_word(sink_word),
    .sink_valid(sink_valid), .sink_sop(sink_sop), .sink_eop(sink_eop), .sink_error(sink_error),
    .sink_ready(sink_ready), .source_word(source_word), .source_valid(source_valid), .source_sop(source_sop),
    .source_eop(source_eop), .source_error(source_error), .source_ready(source_ready));

// >>> test/bes_sink_model.sv
`timescale 1ns/100ps
module bes_sink_model
    import bes_pkg::*;
(
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic stall,
    input wire bes_out_t source_word,
    input wire logic source_valid,
    input wire logic source_sop,
    input wire logic source_eop,
    output logic source_ready,
    output int n_words,
    output int n_sop,
    output int n_eop,
    output logic [2:0] data_or,
    output bes_out_t last_word
);
    logic ph;
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            {n_words, n_sop, n_eop, data_or, last_word} <= '0;
            ph <= 1'b0;
            source_ready <= 1'b1;
        end else begin
            // Words count only on a zero-latency handshake
            if (source_valid && source_ready) begin
                n_words <= n_words + 1;
                n_sop <= n_sop + int'(source_sop);
                n_eop <= n_eop + int'(source_eop);
                data_or <= data_or | source_word.data;
                last_word <= source_word;
            end
            ph <= !ph;
            // Half-rate acceptance when stalling, tied high otherwise
            source_ready <= !stall || ph;
        end
    end
endmodule

// >>> test/bes_encoder_tb.sv
`timescale 1ns/100ps
module bes_encoder_tb;
    import bes_pkg::*;
    localparam int KB = 8;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic stall = 1'b0;
    logic din = 1'b0;
    bes_in_t sink_word = '0;
    logic sink_valid = 1'b0, sink_sop = 1'b0, sink_eop = 1'b0, sink_ready, source_valid, source_sop, source_eop;
    logic [1:0] sink_error = 2'h0, source_error;
    logic source_ready;
    bes_out_t source_word, last_word;
    logic [2:0] data_or;
    int n_fail = 0, compares = 0, n_words, n_sop, n_eop, c, w;
    always #25 mclk = ~mclk;
    bes_encoder i_bes_encoder (.mclk(mclk), .reset_n(reset_n), .sink_word(sink_word), .sink_valid(sink_valid),
        .sink_sop(sink_sop), .sink_eop(sink_eop), .sink_error(sink_error), .sink_ready(sink_ready),
        .ilv_f1(13'h0003), .ilv_f2(13'h0000), .source_word(source_word), .source_valid(source_valid),
        .source_sop(source_sop), .source_eop(source_eop), .source_error(source_error), .source_ready(source_ready));
    bes_sink_model i_bes_sink_model (.mclk(mclk), .reset_n(reset_n), .stall(stall), .source_word(source_word),
        .source_valid(source_valid), .source_sop(source_sop), .source_eop(source_eop), .source_ready(source_ready),
        .n_words(n_words), .n_sop(n_sop), .n_eop(n_eop), .data_or(data_or), .last_word(last_word));
    ////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge mclk);
            #1;
        end
    endtask
    // Holds the beat until an edge that sees ready high
    task automatic beat(input logic sop, input logic eop, input logic [1:0] err);
        int n;
        n = 0;
        {sink_valid, sink_sop, sink_eop, sink_error} = {1'b1, sop, eop, err};
        sink_word = '{size: 13'(KB), data: din};
        while (sink_ready !== 1'b1 && n < 300) begin
            tick(1);
            n++;
        end
        if (n == 300) begin
            n_fail++;
            print_verdict();
        end else tick(1);
    endtask
    task automatic send(input int nb, input int eop_at, input logic sop_ok, input logic [1:0] err, input bit gap);
        for (int i = 0; i < nb; i++) begin
            beat(i == 0 && sop_ok, i == eop_at, err);
            if (gap && i == 2) begin
                sink_valid = 1'b0;
                tick(3);
            end
        end
        sink_valid = 1'b0;
    endtask
    task automatic wait_out(input int target);
        c = 0;
        while (n_words < target && c < 600) begin
            tick(1);
            c++;
        end
        if (c == 600) begin
            n_fail++;
            print_verdict();
        end else tick(2);
    endtask
    task automatic good(input bit gap);
        w = n_words;
        send(KB, KB - 1, 1'b1, 2'h0, gap);
        wait_out(w + KB + 4);
        check("words", n_words - w, KB + 4);
        check("error", source_error, 2'h0);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge mclk);
        #1;
        reset_n = 1'b1;
        tick(1);
        stall = 1'b1;
        good(1'b1);
        check("sop", n_sop, 1);
        check("eop", n_eop, 1);
        check("word", last_word, {13'(KB), 3'h0});
        check("data", data_or, 3'h0);
        stall = 1'b0;
        send(KB, KB - 1, 1'b1, 2'h0, 1'b0);
        c = 0;
        while (sink_ready === 1'b0 && c < 100) begin
            c++;
            tick(1);
        end
        check("busy", c, KB + 14);
        tick(4);
        for (int e = 1; e < 4; e++) begin
            good(1'b0);
            w = n_words;
            send(KB, KB - 1, 1'b1, 2'(e), 1'b0);
            tick(30);
            check("forward", source_error, e);
            check("discard", n_words, w);
        end
        beat(1'b0, 1'b0, 2'h0);
        sink_valid = 1'b0;
        tick(4);
        check("no_sop", source_error, 2'h1);
        send(3, -1, 1'b1, 2'h0, 1'b0);
        send(1, -1, 1'b1, 2'h0, 1'b0);
        tick(4);
        check("no_eop", source_error, 2'h2);
        w = n_words;
        din = 1'b1;
        send(KB - 1, KB - 2, 1'b0, 2'h0, 1'b0);
        wait_out(w + KB + 4);
        check("restart", source_error, 2'h0);
        check("sys", data_or[0], 1'b1);
        din = 1'b0;
        send(4, 3, 1'b1, 2'h0, 1'b0);
        tick(4);
        check("early_eop", source_error, 2'h3);
        print_verdict();
    end
endmodule
